// file: core/sac_adc_ctrl.sv
// Control, result and clock logic of an 8-bit successive-approximation
// converter, with its registers on an AXI4-Lite slave port.
// Assumes the analog comparator answers within one converter clock and that
// crystal_clock is a slow level already synchronous to clk.
//
// Notes on behaviour
// RULE1: Done flag set per conversion, read-only.
// RULE2: Control write or result read clears done.
// RULE3: Done flag reads 0 while interrupt enabled.
// RULE4: Interrupt enabled: request at conversion end.
// RULE5: Result read or control write withdraws request.
// RULE6: Continuous mode converts repeatedly, reloading result.
// RULE7: Single mode: one conversion per start.
// RULE8: Reset clears flags, channel all ones.
// RULE9: Codes 0-14 pick port B/D channels.
// RULE10: Codes 0x0F-0x1A unused, 0x1B reserved.
// RULE11: Codes 0x1C-0x1E route internal reference nodes.
// RULE12: Channel all ones powers converter off.
// RULE13: Software waits one conversion after power-up.
// RULE14: One 8-bit result register, loaded per conversion.
// RULE15: Prescaler divides by 1,2,4,8 or 16.
// RULE16: Source bit: 1 bus clock, 0 crystal.
// RULE17: Software aims converter clock near 1 MHz.
// RULE18: Slow crystal: software picks bus clock.
// RULE19: Software keeps clock settings during conversion.
// RULE20: Sixteen converter clocks, start after control write.
// RULE21: Continuous results overwrite unread ones.
// RULE22: Stop mode aborts; conversions resume afterwards.
// RULE23: Selected pin forced to converter input.
// RULE24: Result and completion appear together.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps

module sac_adc_ctrl
   import sac_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [SAC_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [SAC_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      crystal_clock,
   input  wire logic                      stop_mode,
   input  wire logic                      cmp_above,
   output sac_pkg::sac_ana_out_t          ana,
   output logic                           done_irq
);
   import sac_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic                  aw_got;
      logic [SAC_ADDR_W-1:0] aw_addr;
      logic                  w_got;
      logic [31:0]           w_data;
      logic                  w_lane0;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic                  conversion_done_flag;
      logic                  done_irq_enable;
      logic                  continuous_mode_bit;
      logic [SAC_CH_W-1:0]   channel_select;
      logic [SAC_DIV_W-1:0]  converter_prescaler;
      logic                  converter_clock_source;
      logic                  xtal_q;
      logic [3:0]            div_cnt;
      sac_phase_t            phase;
      logic                  run_req;
      logic [3:0]            step;
      logic [7:0]            sar;
      logic [7:0]            result;
      logic                  irq;
      sac_ana_out_t          ana;
   } sac_state_t;

   sac_state_t st_r;
   sac_state_t st_nxt;
   // All state lives in one struct; st_nxt is its next value

   logic                  aw_fire;
   logic                  w_fire;
   logic                  ar_fire;
   logic                  wr_now;
   logic [SAC_ADDR_W-1:0] wr_addr;
   logic [31:0]           wr_data;
   logic                  wr_lane0;
   logic                  ctrl_wr;
   logic                  result_rd;
   logic                  src_tick;
   logic                  conv_tick;
   logic [3:0]            div_last;
   logic [7:0]            trial;
   logic [7:0]            final_val;
   logic                  powered_off;

   // Ready drops while an answer waits: one write, one read in flight
   assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
   assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign ana           = st_r.ana;
   assign done_irq      = st_r.irq;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire  = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;

      // Bus write: address and data arrive in either order
      wr_addr  = aw_fire ? s_axi_awaddr : st_r.aw_addr;
      wr_data  = w_fire ? s_axi_wdata : st_r.w_data;
      wr_lane0 = w_fire ? s_axi_wstrb[0] : st_r.w_lane0;
      wr_now   = (st_r.aw_got || aw_fire) && (st_r.w_got || w_fire);
      ctrl_wr  = 1'b0;
      if (s_axi_bready && st_r.bvalid) begin
         st_nxt.bvalid = 1'b0;
      end
      if (aw_fire) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_fire) begin
         st_nxt.w_got   = 1'b1;
         st_nxt.w_data  = s_axi_wdata;
         st_nxt.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_now) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = SAC_RESP_OKAY;
         // Only byte lane 0 carries register bits
         case ({wr_addr[SAC_ADDR_W-1:2], 2'b00})
            SAC_OFS_CTRL: begin
               if (wr_lane0) begin
                  ctrl_wr = 1'b1;
                  st_nxt.done_irq_enable     = wr_data[SAC_CTRL_IEN_BIT];
                  st_nxt.continuous_mode_bit = wr_data[SAC_CTRL_CONT_BIT];
                  st_nxt.channel_select =
                     wr_data[SAC_CTRL_CH_LSB +: SAC_CH_W];
               end
            end
            SAC_OFS_RESULT: begin
               // Read-only; the write is accepted and dropped
            end
            SAC_OFS_CLKCFG: begin
               if (wr_lane0) begin
                  st_nxt.converter_prescaler =
                     wr_data[SAC_CLK_DIV_LSB +: SAC_DIV_W];
                  st_nxt.converter_clock_source = wr_data[SAC_CLK_SRC_BIT];
               end
            end
            default: st_nxt.bresp = SAC_RESP_SLVERR;
         endcase
      end

      // Bus read
      // A result read clears at the AR edge, not at rready
      result_rd = 1'b0;
      if (s_axi_rready && st_r.rvalid) begin
         st_nxt.rvalid = 1'b0;
      end
      if (ar_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = SAC_RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         case ({s_axi_araddr[SAC_ADDR_W-1:2], 2'b00})
            SAC_OFS_CTRL: begin
               // Flag is kept under interrupt mode but reads 0
               st_nxt.rdata[SAC_CTRL_DONE_BIT] =
                  st_r.conversion_done_flag && !st_r.done_irq_enable; // RULE3
               st_nxt.rdata[SAC_CTRL_IEN_BIT]  = st_r.done_irq_enable;
               st_nxt.rdata[SAC_CTRL_CONT_BIT] = st_r.continuous_mode_bit;
               st_nxt.rdata[SAC_CTRL_CH_LSB +: SAC_CH_W] =
                  st_r.channel_select;
            end
            SAC_OFS_RESULT: begin
               st_nxt.rdata[7:0] = st_r.result;
               result_rd = 1'b1;
            end
            SAC_OFS_CLKCFG: begin
               st_nxt.rdata[SAC_CLK_DIV_LSB +: SAC_DIV_W] =
                  st_r.converter_prescaler;
               st_nxt.rdata[SAC_CLK_SRC_BIT] = st_r.converter_clock_source;
            end
            default: st_nxt.rresp = SAC_RESP_SLVERR;
         endcase
      end

      // Clearing comes first so that a completion in the same cycle wins
      if (ctrl_wr || result_rd) begin
         st_nxt.conversion_done_flag = 1'b0; // RULE2
         st_nxt.irq                  = 1'b0; // RULE5
      end

      // Converter clock: bus clock ticks every cycle, crystal on its edge
      // Edge register resets low: a high crystal gives one early
      // tick, harmless as nothing is armed before a control write
      st_nxt.xtal_q = crystal_clock;
      src_tick = st_r.converter_clock_source ||
                 (crystal_clock && !st_r.xtal_q); // RULE16
      case (st_r.converter_prescaler)
         3'h0:    div_last = 4'h0;
         3'h1:    div_last = 4'h1;
         3'h2:    div_last = 4'h3;
         3'h3:    div_last = 4'h7;
         default: div_last = 4'hf;
      endcase // RULE15
      // Free counter, never re-phased by a start: a single run
      // therefore takes 16 to 17 converter clocks
      conv_tick = 1'b0;
      if (src_tick) begin
         if (st_r.div_cnt >= div_last) begin
            st_nxt.div_cnt = 4'h0;
            conv_tick      = 1'b1;
         end else begin
            st_nxt.div_cnt = st_r.div_cnt + 4'h1;
         end
      end

      // Successive approximation: sample, then one bit per clock, MSB first
      trial = st_r.sar | (SAC_SAR_MSB >> (st_r.step - SAC_SAMPLE_CLOCKS));
      if (st_r.step < SAC_SAMPLE_CLOCKS) begin
         trial = st_r.sar;
      end
      // The comparator is trusted only at ticks, once ana.trial
      // has stood for a whole converter clock
      final_val = cmp_above ? trial : st_r.sar;
      // Power-off blocks a start even with a request armed
      powered_off = (st_r.channel_select == SAC_CH_POWER_OFF);

      // Priority: control write, then stop or power-off, then ticks
      if (ctrl_wr) begin
         // A control write restarts; the next converter edge begins it
         st_nxt.phase   = SAC_IDLE; // RULE20
         st_nxt.step    = 4'h0;
         st_nxt.sar     = 8'h00;
         st_nxt.run_req = (st_nxt.channel_select != SAC_CH_POWER_OFF);
      end else if (stop_mode || powered_off) begin
         // Abort; run_req survives stop so the work resumes on exit
         st_nxt.phase = SAC_IDLE; // RULE22 RULE12
         st_nxt.step  = 4'h0;
         st_nxt.sar   = 8'h00;
      end else if (conv_tick) begin
         case (st_r.phase)
            SAC_IDLE: begin
               if (st_r.run_req) begin
                  st_nxt.phase = SAC_CONV; // RULE20
                  st_nxt.step  = 4'h0;
                  st_nxt.sar   = 8'h00;
               end
            end
            SAC_CONV: begin
               if (st_r.step >= SAC_SAMPLE_CLOCKS && cmp_above) begin
                  st_nxt.sar = trial;
               end
               st_nxt.step = st_r.step + 4'h1;
               if (st_r.step == SAC_CONV_LAST) begin
                  st_nxt.result = final_val; // RULE14 RULE21
                  st_nxt.conversion_done_flag = 1'b1; // RULE1 RULE24
                  if (st_r.done_irq_enable) begin
                     st_nxt.irq = 1'b1; // RULE4 RULE24
                  end
                  st_nxt.step = 4'h0;
                  st_nxt.sar  = 8'h00;
                  if (!st_r.continuous_mode_bit) begin
                     st_nxt.phase   = SAC_IDLE; // RULE7
                     st_nxt.run_req = 1'b0;
                  end // RULE6
               end
            end
            default: st_nxt.phase = SAC_IDLE;
         endcase
      end

      // Analog side; unused codes still convert, giving whatever the mux
      // delivers, and internal reference codes pass through as selects
      st_nxt.ana.power_on = (st_nxt.channel_select != SAC_CH_POWER_OFF);
      st_nxt.ana.sample   = (st_nxt.phase == SAC_CONV) &&
                            (st_nxt.step < SAC_SAMPLE_CLOCKS);
      st_nxt.ana.trial = st_nxt.sar |
         (SAC_SAR_MSB >> (st_nxt.step - SAC_SAMPLE_CLOCKS));
      if (st_nxt.step < SAC_SAMPLE_CLOCKS) begin
         st_nxt.ana.trial = st_nxt.sar;
      end
      st_nxt.ana.selected_analog_input =
         st_nxt.channel_select; // RULE11 RULE10
      for (int i = 0; i < 8; i++) begin
         st_nxt.ana.portb_override[i] =
            (st_nxt.channel_select == 5'(i)); // RULE9 RULE23
      end
      for (int i = 0; i < 7; i++) begin
         st_nxt.ana.portd_override[i] =
            (st_nxt.channel_select == 5'(i + 8)); // RULE9 RULE23
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk) begin
      if (rst) begin
         // Clear all, then set each field's reset value by name; only the channel codes are not zero
         st_r                        <= '0;
         st_r.bresp                  <= SAC_RESP_OKAY;
         st_r.rresp                  <= SAC_RESP_OKAY;
         st_r.conversion_done_flag   <= 1'b0; // RULE8
         st_r.done_irq_enable        <= 1'b0; // RULE8
         st_r.continuous_mode_bit    <= 1'b0; // RULE8
         st_r.channel_select         <= SAC_CH_POWER_OFF; // RULE8
         st_r.converter_prescaler    <= SAC_DIV_RESET;
         st_r.converter_clock_source <= SAC_SRC_RESET; // RULE16
         st_r.phase                  <= SAC_IDLE;
         st_r.ana.selected_analog_input <= SAC_CH_POWER_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // sac_adc_ctrl

// file: core/sac_pkg.sv
// Constants, register layout and carrier types of the converter control block.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register port.
package sac_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses) and bus answers
   localparam int          SAC_ADDR_W      = 8;
   localparam logic [7:0]  SAC_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  SAC_OFS_RESULT  = 8'h04;
   localparam logic [7:0]  SAC_OFS_CLKCFG  = 8'h08;
   localparam logic [1:0]  SAC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  SAC_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of conversion_control
   localparam int SAC_CTRL_DONE_BIT = 7;
   localparam int SAC_CTRL_IEN_BIT  = 6;
   localparam int SAC_CTRL_CONT_BIT = 5;
   localparam int SAC_CTRL_CH_LSB   = 0;
   localparam int SAC_CH_W          = 5;
   // Field positions of converter_clock_config
   localparam int SAC_CLK_DIV_LSB   = 5;
   localparam int SAC_DIV_W         = 3;
   localparam int SAC_CLK_SRC_BIT   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset, and the last port B and port D channel codes
   localparam logic [4:0] SAC_CH_POWER_OFF  = 5'h1f;
   localparam logic [4:0] SAC_CH_LAST_PORTB = 5'h07;
   localparam logic [4:0] SAC_CH_LAST_PORTD = 5'h0e;
   localparam logic [2:0] SAC_DIV_RESET     = 3'h0;
   localparam logic       SAC_SRC_RESET     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion timing in converter clocks, and the first trial bit
   localparam logic [3:0] SAC_CONV_LAST     = 4'hf;
   localparam logic [3:0] SAC_SAMPLE_CLOCKS = 4'h8;
   localparam logic [7:0] SAC_SAR_MSB       = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic {
      SAC_IDLE,
      SAC_CONV
   } sac_phase_t;

   typedef struct packed {
      logic       power_on;
      logic       sample;
      logic [7:0] trial;
      logic [4:0] selected_analog_input;
      logic [7:0] portb_override;
      logic [6:0] portd_override;
   } sac_ana_out_t;

endpackage

// file: dv/sac_adc_ctrl_props.sv
// Port assertions for the converter control block.
// Assumes it is bound to sac_adc_ctrl with ports connected by name.
`timescale 1ns/10ps
module sac_adc_ctrl_props (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic [7:0]             s_axi_awaddr,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic [31:0]            s_axi_wdata,
   input wire logic [3:0]             s_axi_wstrb,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic [7:0]             s_axi_araddr,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic                   stop_mode,
   input wire sac_pkg::sac_ana_out_t  ana,
   input wire logic                   done_irq
);
   import sac_pkg::*;
   logic irq_en_r;
   wire  wr_any = s_axi_awvalid && s_axi_awready &&
                  s_axi_wvalid && s_axi_wready;
   wire  wr_ctl = wr_any && s_axi_awaddr[7:2] == 6'h0 && s_axi_wstrb[0];
   wire  rd_res = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h1;
   wire  [4:0] ch = ana.selected_analog_input;
   // Shadow of the enable bit, so the request line can be judged alone
   always_ff @(posedge clk) begin
      irq_en_r <= rst ? 1'b0 : (wr_ctl ? s_axi_wdata[6] : irq_en_r);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   reset_vals_a: assert property (disable iff (1'b0) rst |=> !done_irq
      && !ana.power_on && ch == SAC_CH_POWER_OFF) else $error("reset state");
   power_off_a: assert property ((ana.power_on == (ch != 5'h1f))
      && (ana.power_on || !ana.sample)) else $error("power state");
   portb_map_a: assert property (ana.portb_override ==
      ((ch <= SAC_CH_LAST_PORTB) ? 8'h01 << ch[2:0] : 8'h00)) else $error("b");
   portd_map_a: assert property (ana.portd_override ==
      ((ch >= 5'h08 && ch <= SAC_CH_LAST_PORTD) ? 7'h01 << ch[2:0] : 7'h00))
      else $error("portd override");
   write_clr_a: assert property (wr_ctl |=> !done_irq)
      else $error("write kept request");
   read_clr_a: assert property (rd_res && done_irq |=> !done_irq)
      else $error("read kept request");
   irq_gate_a: assert property (!irq_en_r |-> !done_irq)
      else $error("request while disabled");
   stop_idle_a: assert property (stop_mode [*2] |-> !ana.sample)
      else $error("sampling in stop");
   write_resp_a: assert property (wr_any |=> s_axi_bvalid)
      else $error("no write response");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   cover property ($rose(done_irq));
   cover property (stop_mode && ana.power_on);
   cover property (s_axi_bvalid && s_axi_bresp == SAC_RESP_SLVERR);
endmodule // sac_adc_ctrl_props

// file: dv/sac_ana_model.sv
// Ideal comparator and input multiplexer facing the converter block.
// Assumes ana is registered by the block; level_shift comes from the bench.
`timescale 1ns/10ps
module sac_ana_model (
   input  wire logic                  clk,
   input  wire sac_pkg::sac_ana_out_t ana,
   input  wire logic [7:0]            level_shift,
   output logic                       cmp_above
);
   import sac_pkg::*;
   logic [7:0] level;
   logic       churn_r = 1'b0;
   always_comb begin
      case (ana.selected_analog_input)
         5'h1c, 5'h1d: level = 8'hff;
         5'h1e:        level = 8'h00;
         default:      level = {ana.selected_analog_input, 3'h5} + level_shift;
      endcase
   end
   // Unpowered or sampling: no valid answer, so the line keeps changing
   always_ff @(posedge clk) churn_r <= ~churn_r;
   assign cmp_above = (ana.power_on && !ana.sample) ? level >= ana.trial
                                                    : churn_r;
endmodule // sac_ana_model

// file: dv/sac_adc_ctrl_test.sv
// Self-checking bench for the converter control block.
// Assumes the ideal comparator model and a crystal clock of clk/10.
`timescale 1ns/10ps
module sac_adc_ctrl_test;
   import sac_pkg::*;
   logic         clk = 1'b0, rst = 1'b1, xclk = 1'b0, stop = 1'b0;
   logic [7:0]   awaddr = 8'h0, araddr = 8'h0, shift = 8'h0;
   logic [31:0]  wdata = 32'h0, rdata;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic         arvalid = 1'b0, rready = 1'b0;
   logic         awready, wready, bvalid, arready, rvalid, cmp, irq;
   logic [1:0]   bresp, rresp;
   sac_ana_out_t ana;
   int           errors = 0, checks_done = 0, xcnt = 0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      xcnt <= (xcnt == 9) ? 0 : xcnt + 1;
      xclk <= xcnt < 5;
   end
   sac_adc_ctrl dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .crystal_clock(xclk), .stop_mode(stop),
      .cmp_above(cmp), .ana(ana), .done_irq(irq));
   sac_ana_model far (.clk(clk), .ana(ana), .level_shift(shift),
      .cmp_above(cmp));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lvl(input logic [4:0] c,
                                      input logic [7:0] s);
      if (c == 5'h1e) return 8'h00;
      if (c >= 5'h1c) return 8'hff;
      return {c, 3'h5} + s;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Each channel is released at the edge where it is seen taken
   task automatic bus(input logic w, input logic [7:0] a, d,
                      output logic [31:0] q, output logic [1:0] r);
      int   n;
      logic ta, tw, tr, fin;
      n = 0;
      fin = 1'b0;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= {24'h0, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      rready <= !w;
      arvalid <= !w;
      while (!fin && n < 200) begin
         @(negedge clk);
         n++;
         ta = awvalid && awready;
         tw = wvalid && wready;
         tr = arvalid && arready;
         fin = w ? bvalid && bready : rvalid && rready;
         q = rdata;
         r = w ? bresp : rresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         if (fin) begin
            bready <= 1'b0;
            rready <= 1'b0;
         end
      end
      chk("handshake", 1, fin);
   endtask
   task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b1, a, d, q, r);
      chk("bresp", er, r);
   endtask
   task automatic rdc(input logic [7:0] a, e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, a, 8'h0, q, r);
      chk("rresp", er, r);
      chk($sformatf("reg %h", a), {24'h0, e}, q);
   endtask
   task automatic poll(input logic [7:0] e);
      logic [31:0] q;
      logic [1:0]  r;
      int          n;
      n = 0;
      do begin
         bus(1'b0, SAC_OFS_CTRL, 8'h0, q, r);
         n++;
      end while (!q[7] && n < 100);
      chk("control", {24'h0, e}, q);
   endtask
   task automatic cnt_irq(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!irq && n < 3000);
   endtask
   task automatic starts(input int e);
      int   k;
      logic p;
      k = 0;
      p = ana.sample;
      repeat (64) begin
         @(negedge clk);
         k += int'(ana.sample && !p);
         p = ana.sample;
      end
      chk("starts", e, k);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(SAC_OFS_CTRL, 8'h1f, SAC_RESP_OKAY);
      rdc(SAC_OFS_CLKCFG, 8'h00, SAC_RESP_OKAY);
      rdc(8'h0c, 8'h00, SAC_RESP_SLVERR);
      wr(8'h0c, 8'h55, SAC_RESP_SLVERR);
      wr(SAC_OFS_RESULT, 8'haa, SAC_RESP_OKAY);
      rdc(SAC_OFS_RESULT, 8'h00, SAC_RESP_OKAY);
      $display("test reset done");
   endtask
   task automatic t_single();
      logic [4:0] c [7] = '{5'h00, 5'h07, 5'h08, 5'h0e, 5'h1c, 5'h1d, 5'h1e};
      wr(SAC_OFS_CLKCFG, 8'h10, SAC_RESP_OKAY);
      wr(SAC_OFS_CTRL, 8'h00, SAC_RESP_OKAY);
      poll(8'h80);
      foreach (c[i]) begin
         wr(SAC_OFS_CTRL, {3'h0, c[i]}, SAC_RESP_OKAY);
         poll({3'h4, c[i]});
         rdc(SAC_OFS_RESULT, lvl(c[i], 8'h0), SAC_RESP_OKAY);
         rdc(SAC_OFS_CTRL, {3'h0, c[i]}, SAC_RESP_OKAY);
      end
      starts(0);
      $display("test single done");
   endtask
   task automatic t_irq();
      logic [2:0] dv [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      int         n, d;
      foreach (dv[i]) begin
         d = dv[i][2] ? 16 : 1 << dv[i];
         wr(SAC_OFS_CLKCFG, {dv[i], 5'h10}, SAC_RESP_OKAY);
         wr(SAC_OFS_CTRL, 8'h43, SAC_RESP_OKAY);
         cnt_irq(n);
         chk("ticks", 1, n > 16 * d && n <= 17 * d);
         rdc(SAC_OFS_CTRL, 8'h43, SAC_RESP_OKAY);
         rdc(SAC_OFS_RESULT, lvl(5'h03, 8'h0), SAC_RESP_OKAY);
         chk("irq", 0, irq);
      end
      wr(SAC_OFS_CLKCFG, 8'h80, SAC_RESP_OKAY);
      wr(SAC_OFS_CTRL, 8'h43, SAC_RESP_OKAY);
      cnt_irq(n);
      chk("crystal ticks", 1, n > 2560 && n <= 2720);
      wr(SAC_OFS_CTRL, 8'h5f, SAC_RESP_OKAY);
      chk("irq", 0, irq);
      $display("test irq done");
   endtask
   task automatic t_cont();
      wr(SAC_OFS_CLKCFG, 8'h10, SAC_RESP_OKAY);
      wr(SAC_OFS_CTRL, 8'h25, SAC_RESP_OKAY);
      poll(8'ha5);
      starts(4);
      shift = 8'h0b;
      repeat (40) @(negedge clk);
      rdc(SAC_OFS_RESULT, lvl(5'h05, 8'h0b), SAC_RESP_OKAY);
      wr(SAC_OFS_CTRL, 8'h05, SAC_RESP_OKAY);
      rdc(SAC_OFS_CTRL, 8'h05, SAC_RESP_OKAY);
      repeat (20) @(negedge clk);
      starts(0);
      shift = 8'h00;
      $display("test continuous done");
   endtask
   task automatic t_stop();
      wr(SAC_OFS_CTRL, 8'h03, SAC_RESP_OKAY);
      repeat (12) @(negedge clk);
      @(posedge clk);
      stop <= 1'b1;
      repeat (40) @(negedge clk);
      chk("sample", 0, ana.sample);
      rdc(SAC_OFS_CTRL, 8'h03, SAC_RESP_OKAY);
      @(posedge clk);
      stop <= 1'b0;
      poll(8'h83);
      rdc(SAC_OFS_RESULT, lvl(5'h03, 8'h0), SAC_RESP_OKAY);
      $display("test stop done");
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_single();
      t_irq();
      t_cont();
      t_stop();
      summarize();
   end
   initial begin
      #100000;
      errors++;
      $display("wrong value watchdog expected end seen hang");
      summarize();
   end
endmodule // sac_adc_ctrl_test
bind sac_adc_ctrl sac_adc_ctrl_props u_props (.clk(clk), .rst(rst),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .stop_mode(stop_mode), .ana(ana),
   .done_irq(done_irq));
